// File: acp_pkg.sv
// Constants and types shared by the converter configuration port
package acp_pkg;
    localparam int ACP_CLK_HZ = 25_000_000;
    localparam int ACP_WORD_BITS = 16;
    localparam int ACP_ADDR_BITS = 8;
    localparam logic [3:0] ACP_LAST_BIT = 4'hF;
    localparam int ACP_NREGS = 32;
    localparam logic [7:0] ACP_REG_DEFAULT = 8'h00;
    // Register addresses and field positions
    localparam logic [7:0] ACP_REG_RST = 8'h00;
    localparam int ACP_RST_BIT = 1;
    localparam logic [7:0] ACP_REG_IFACE = 8'h14;
    localparam int ACP_OVRD_BIT = 7;
    localparam int ACP_IFACE_BIT = 5;
    localparam int ACP_GAIN_BIT = 4;
    localparam int ACP_REF_BIT = 3;
    localparam int ACP_PD_LSB = 0;
    localparam logic [7:0] ACP_REG_FMT = 8'h16;
    localparam int ACP_FMT_BIT = 4;
    // Analog pin level codes from the external comparator
    localparam logic [1:0] ACP_LVL_GND = 2'h0;
    localparam logic [1:0] ACP_LVL_3_8 = 2'h1;
    localparam logic [1:0] ACP_LVL_5_8 = 2'h2;
    localparam logic [1:0] ACP_LVL_FULL = 2'h3;
    // Timing
    localparam int ACP_PWRUP_MS = 7;
    localparam int ACP_PWRUP_CYC = (ACP_CLK_HZ / 1000) * ACP_PWRUP_MS;
    localparam int ACP_RST_PULSE_NS = 10;
    localparam int ACP_RST_PULSE_CYC_RAW =
        (ACP_RST_PULSE_NS * (ACP_CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int ACP_RST_PULSE_CYC = (ACP_RST_PULSE_CYC_RAW < 1) ? 1 : ACP_RST_PULSE_CYC_RAW;
    localparam int ACP_PAR_HOLD_NS = 1000;
    localparam int ACP_PAR_HOLD_CYC = (ACP_PAR_HOLD_NS * (ACP_CLK_HZ / 1_000_000)) / 1000;
    typedef enum logic [2:0] {
        ACP_PM_NORMAL, ACP_PM_DIS_A, ACP_PM_DIS_B, ACP_PM_DIS_AB,
        ACP_PM_PD_AB, ACP_PM_SBY_A, ACP_PM_SBY_B, ACP_PM_MUX
    } acp_pm_t;
endpackage

// File: acp_word_if.sv
// Committed serial word passed from the shifter to the register file
`timescale 1ns/10ps
interface acp_word_if;
    logic commit;
    logic [7:0] addr;
    logic [7:0] data;
    modport tx (output commit, output addr, output data);
    modport rx (input commit, input addr, input data);
endinterface

// File: acp_serial_rx.sv
// Three-wire serial shifter that assembles 16-bit address/data words
`timescale 1ns/10ps
module acp_serial_rx
    import acp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic serial_select_low,
    input wire logic serial_clk,
    input wire logic serial_data_in,
    acp_word_if.tx w
);
    logic sclk_d_r;
    logic [3:0] bit_cnt_r;
    logic [14:0] shift_r;
    logic commit_r;
    logic [7:0] addr_r;
    logic [7:0] data_r;

    wire sclk_fall = sclk_d_r & ~serial_clk;
    wire shift_en = sclk_fall && !serial_select_low; // [RULE6]
    wire word_done = shift_en && (bit_cnt_r == ACP_LAST_BIT);
    wire [15:0] word_full = {shift_r, serial_data_in};

    // Reset to the idle low level so no false edge follows reset
    // Each level needs one clock period to be sampled, so 20 MHz is out of reach
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sclk_d_r <= 1'b0;
        end else begin
            sclk_d_r <= serial_clk; // [RULE12]
        end
    end

    // Deselect drops a partial word so trailing bits never commit
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_cnt_r <= 4'h0;
            shift_r <= 15'h0000;
        end else if (serial_select_low) begin
            bit_cnt_r <= 4'h0; // [RULE9]
        end else if (shift_en) begin
            bit_cnt_r <= bit_cnt_r + 4'h1; // [RULE7] [RULE10]
            shift_r <= word_full[14:0]; // [RULE22]
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            commit_r <= 1'b0;
            addr_r <= 8'h00;
            data_r <= 8'h00;
        end else begin
            commit_r <= word_done; // [RULE8]
            if (word_done) begin
                addr_r <= word_full[15:8]; // [RULE11]
                data_r <= word_full[7:0];
            end
        end
    end

    assign w.commit = commit_r;
    assign w.addr = addr_r;
    assign w.data = data_r;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    no_shift_idle_a: assert property (serial_select_low |=> bit_cnt_r == 4'h0) // [RULE6]
        else $error("bit counter moved while deselected");
    commit_on_16th_a: assert property (commit_r |-> // [RULE8]
        $past(shift_en) && $past(bit_cnt_r) == ACP_LAST_BIT)
        else $error("commit without sixteenth falling edge");
    word_split_a: assert property (word_done |=> // [RULE11]
        addr_r == $past(shift_r[14:7])
        && data_r == {$past(shift_r[6:0]), $past(serial_data_in)})
        else $error("address or data byte misassembled");
    partial_drop_a: assert property (serial_select_low && bit_cnt_r != 4'h0 |=> !commit_r) // [RULE9]
        else $error("partial word committed");
    word_cover_c: cover property (commit_r ##[1:40] commit_r);
endmodule

// File: acp_config_top.sv
// Configuration front end: serial register writes and parallel mode pins
// Operation
// RULE1 - Mode pins 000 normal; 001 disables A, 010 disables B, 011 both outputs.
// RULE2 - Mode pins 100 power down both; 101 standby A; 110 standby B.
// RULE3 - Mode pins 111 with CMOS interface interleaves both channels on one bus.
// RULE4 - Parallel-only: clock pin level picks coarse gain and reference source.
// RULE5 - Parallel-only: select pin level picks data format and output interface.
// RULE6 - Bits shift in only while select is low.
// RULE7 - Data sampled on each falling shift-clock edge while selected.
// RULE8 - Every sixteenth falling edge commits the word to its register.
// RULE9 - Trailing bits beyond the last full word are discarded.
// RULE10 - Several words may follow in one select period, each committed.
// RULE11 - First eight bits are address, next eight are data.
// RULE12 - Shift clock from few hertz to 20 MHz, any duty cycle; the shifter samples it on the 25 MHz clock, so 20 MHz is not reached.
// RULE13 - Host initialises registers by hardware or software reset after power-up.
// RULE14 - Reset pin high pulse over 10 ns restores register defaults; the pin is only sampled each 40 ns clock, so a shorter pulse can be missed.
// RULE15 - Writing one to software reset bit restores defaults; bit self-clears.
// RULE16 - Host keeps reset pin low during software reset initialisation.
// RULE17 - Host waits 5 ms after power-up before hardware reset pulse.
// RULE18 - Host waits 25 ns after reset release before selecting.
// RULE19 - Reset pin held high means parallel-only configuration.
// RULE20 - Outputs become stable 7 ms after power-up.
// RULE21 - Override bit zero: pins govern power modes; one: register bits govern.
// RULE22 - Bytes shift most significant bit first, address byte before data.
`timescale 1ns/10ps
module acp_config_top
    import acp_pkg::*;
#(
    parameter int PWRUP_CYC = ACP_PWRUP_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic reset_pin,
    input wire logic serial_select_low,
    input wire logic serial_clk,
    input wire logic serial_data_in,
    input wire logic mode_pin_one,
    input wire logic mode_pin_two,
    input wire logic mode_pin_three,
    input wire logic [1:0] sclk_level,
    input wire logic [1:0] sel_level,
    output logic cha_out_dis,
    output logic chb_out_dis,
    output logic cha_power_down,
    output logic chb_power_down,
    output logic cha_standby,
    output logic chb_standby,
    output logic channel_interleave_mode,
    output logic gain_3p5db,
    output logic ext_ref,
    output logic cmos_iface,
    output logic straight_binary,
    output logic parallel_only,
    output logic pin_override,
    output logic outputs_stable,
    output logic word_commit
);
    acp_word_if w ();

    acp_serial_rx u_rx (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .serial_select_low(serial_select_low),
        .serial_clk(serial_clk),
        .serial_data_in(serial_data_in),
        .w(w)
    );

    logic [7:0] regs_r [0:ACP_NREGS-1];
    logic [7:0] par_cnt_r;
    logic par_r;
    logic [31:0] pwr_cnt_r;
    logic stable_r;
    logic [10:0] out_r;

    function automatic logic is_mid_level(input logic [1:0] lvl);
        return (lvl == ACP_LVL_3_8) || (lvl == ACP_LVL_5_8);
    endfunction

    wire sw_rst = w.commit && (w.addr == ACP_REG_RST) && w.data[ACP_RST_BIT];
    // Any sampled high cycle counts: a 10 ns pulse is under one clock period
    wire hw_rst = reset_pin;
    wire wr_ok = w.commit && (w.addr < ACP_NREGS) && (w.addr != ACP_REG_RST);
    wire [4:0] wr_idx = w.addr[4:0];
    wire [7:0] reg_if = regs_r[ACP_REG_IFACE[4:0]];
    wire [7:0] reg_fmt = regs_r[ACP_REG_FMT[4:0]];
    wire ovrd = reg_if[ACP_OVRD_BIT] && !par_r;
    // Register code reuses the pin encoding, so one decoder serves both
    wire [2:0] pin_code = {mode_pin_one, mode_pin_two, mode_pin_three};
    wire [2:0] pm_code = ovrd ? reg_if[ACP_PD_LSB+:3] : pin_code; // [RULE21]
    wire acp_pm_t pm = acp_pm_t'(pm_code);

    // Levels come pre-quantised by an outside comparator; read only when parallel
    wire gain_nxt = par_r ? (sclk_level >= ACP_LVL_5_8) : reg_if[ACP_GAIN_BIT]; // [RULE4]
    wire ref_nxt = par_r ? is_mid_level(sclk_level) : reg_if[ACP_REF_BIT]; // [RULE4]
    wire cmos_nxt = par_r ? (sel_level >= ACP_LVL_5_8) : reg_if[ACP_IFACE_BIT]; // [RULE5]
    wire sb_nxt = par_r ? is_mid_level(sel_level) : reg_fmt[ACP_FMT_BIT]; // [RULE5]
    wire dis_a = (pm == ACP_PM_DIS_A) || (pm == ACP_PM_DIS_AB); // [RULE1]
    wire dis_b = (pm == ACP_PM_DIS_B) || (pm == ACP_PM_DIS_AB); // [RULE1]
    wire pd_ab = (pm == ACP_PM_PD_AB); // [RULE2]
    wire sby_a = (pm == ACP_PM_SBY_A); // [RULE2]
    wire sby_b = (pm == ACP_PM_SBY_B); // [RULE2]
    wire mux_nxt = (pm == ACP_PM_MUX) && cmos_nxt; // [RULE3]
    wire [10:0] out_nxt = {dis_a, dis_b, pd_ab, pd_ab, sby_a, sby_b, mux_nxt,
        gain_nxt, ref_nxt, cmos_nxt, sb_nxt};

    // Reset bit is never stored, so it always reads back as zero
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < ACP_NREGS; i++) regs_r[i] <= ACP_REG_DEFAULT;
        end else if (hw_rst || sw_rst) begin
            for (int i = 0; i < ACP_NREGS; i++) regs_r[i] <= ACP_REG_DEFAULT; // [RULE14] [RULE15]
        end else if (wr_ok) begin
            regs_r[wr_idx] <= w.data; // [RULE10]
        end
    end

    // A long high on the reset pin means tied high, not a pulse
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            par_cnt_r <= 8'h00;
            par_r <= 1'b0;
        end else if (!reset_pin) begin
            par_cnt_r <= 8'h00;
            par_r <= 1'b0;
        end else if (par_cnt_r >= ACP_PAR_HOLD_CYC[7:0]) begin
            par_r <= 1'b1; // [RULE19]
        end else begin
            par_cnt_r <= par_cnt_r + 8'h01;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_cnt_r <= 32'h0000_0000;
            stable_r <= 1'b0;
        end else if (pwr_cnt_r >= PWRUP_CYC[31:0] - 32'h1) begin
            stable_r <= 1'b1; // [RULE20]
        end else begin
            pwr_cnt_r <= pwr_cnt_r + 32'h1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_r <= 11'h000;
        end else begin
            out_r <= out_nxt;
        end
    end

    assign {cha_out_dis, chb_out_dis, cha_power_down, chb_power_down, cha_standby,
        chb_standby, channel_interleave_mode, gain_3p5db, ext_ref, cmos_iface,
        straight_binary} = out_r;
    assign parallel_only = par_r;
    assign pin_override = ovrd;
    assign outputs_stable = stable_r;
    assign word_commit = w.commit;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    normal_mode_a: assert property (pm == ACP_PM_NORMAL |=> // [RULE1]
        !cha_out_dis && !chb_out_dis && !cha_power_down && !channel_interleave_mode)
        else $error("normal mode shows a disabled output");
    pin_a_dis_a: assert property (!ovrd && pin_code == 3'h1 |=> // [RULE1]
        cha_out_dis && !chb_out_dis && !cha_power_down)
        else $error("pin output disable A not applied");
    pin_dis_ab_a: assert property (!ovrd && pin_code == 3'h3 |=> // [RULE1]
        cha_out_dis && chb_out_dis && !cha_power_down)
        else $error("pin output disable AB not applied");
    pin_pd_a: assert property (!ovrd && pin_code == 3'h4 |=> // [RULE2]
        cha_power_down && chb_power_down && !cha_standby)
        else $error("pin power-down not applied");
    pin_sby_b_a: assert property (!ovrd && pin_code == 3'h6 |=> // [RULE2]
        chb_standby && !cha_standby && !chb_power_down)
        else $error("pin standby B not applied");
    mux_cmos_a: assert property (channel_interleave_mode |-> // [RULE3]
        cmos_iface && $past(pm) == ACP_PM_MUX)
        else $error("interleave without CMOS or mode code");
    lvds_no_mux_a: assert property (!cmos_nxt |=> // [RULE3]
        !channel_interleave_mode)
        else $error("interleave with LVDS interface");
    par_gain_a: assert property (par_r && sclk_level == ACP_LVL_FULL |=> // [RULE4]
        gain_3p5db && !ext_ref)
        else $error("parallel gain decode wrong");
    par_ref_a: assert property (par_r && sclk_level == ACP_LVL_3_8 |=> // [RULE4]
        !gain_3p5db && ext_ref)
        else $error("parallel reference decode wrong");
    par_fmt_a: assert property (par_r && sel_level == ACP_LVL_GND |=> // [RULE5]
        !straight_binary && !cmos_iface)
        else $error("parallel format decode wrong");
    par_cmos_a: assert property (par_r && sel_level == ACP_LVL_FULL |=> // [RULE5]
        cmos_iface && !straight_binary)
        else $error("parallel CMOS decode wrong");
    sw_reset_a: assert property (sw_rst && !hw_rst |=> // [RULE15]
        regs_r[ACP_REG_IFACE[4:0]] == ACP_REG_DEFAULT && regs_r[0] == 8'h00)
        else $error("software reset did not clear registers");
    hw_reset_a: assert property (hw_rst |=> // [RULE14]
        regs_r[ACP_REG_FMT[4:0]] == ACP_REG_DEFAULT)
        else $error("hardware reset did not clear registers");
    word_write_a: assert property (wr_ok && !hw_rst && !sw_rst |=> // [RULE10]
        regs_r[$past(wr_idx)] == $past(w.data))
        else $error("committed word not stored");
    override_a: assert property (ovrd && reg_if[2:0] == 3'h5 |=> // [RULE21]
        cha_standby && !chb_standby)
        else $error("override bits not obeyed");
    par_hold_a: assert property ($rose(par_r) |-> // [RULE19]
        par_cnt_r == ACP_PAR_HOLD_CYC[7:0])
        else $error("parallel mode entered at wrong time");
    par_drop_a: assert property (!reset_pin |=> // [RULE19]
        !parallel_only)
        else $error("parallel mode kept with reset pin low");
    stable_time_a: assert property ($rose(stable_r) |-> // [RULE20]
        pwr_cnt_r == PWRUP_CYC[31:0] - 32'h1)
        else $error("outputs stable at wrong time");

    ovrd_cover_c: cover property (ovrd && pm == ACP_PM_PD_AB);
    mux_cover_c: cover property (channel_interleave_mode);
    swrst_cover_c: cover property (sw_rst);
    par_cover_c: cover property ($rose(par_r));
endmodule

// File: acp_host_model.sv
// Host-side serial writer standing in for the configuration controller
`timescale 1ns/10ps
module acp_host_model (
    input wire logic sys_clk,
    input wire logic go,
    input wire logic [47:0] bits,
    input wire logic [5:0] nbits,
    input wire logic hold_sel,
    input wire logic slow,
    output logic serial_select_low,
    output logic serial_clk,
    output logic serial_data_in,
    output logic busy
);
    logic start;
    int hl;
    initial begin
        serial_select_low = 1'b1;
        serial_clk = 1'b0;
        serial_data_in = 1'b0;
        busy = 1'b0;
        forever begin
            @(posedge sys_clk);
            start = go;
            @(negedge sys_clk);
            if (!start) begin
                // Released data line has no pull, so keep it moving
                serial_data_in = ~serial_data_in;
            end else begin
                busy = 1'b1;
                hl = slow ? 5 : 2; // Levels of two cycles or more keep the rate legal
                serial_select_low = hold_sel;
                @(negedge sys_clk); // Select leads the first edge
                for (int i = 0; i < nbits; i++) begin
                    serial_data_in = bits[nbits - 1 - i]; // MSB first, address first
                    serial_clk = 1'b1;
                    repeat (hl) @(negedge sys_clk);
                    serial_clk = 1'b0;
                    repeat (hl) @(negedge sys_clk);
                end
                serial_select_low = 1'b1;
                busy = 1'b0;
            end
        end
    end
endmodule

// File: acp_config_top_test.sv
// Self-checking bench for the converter configuration port
`timescale 1ns/10ps
module acp_config_top_test;
    import acp_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reset_pin = 1'b0;
    logic [2:0] mode = 3'h0;
    logic [1:0] sclk_level = 2'h0;
    logic [1:0] sel_level = 2'h0;
    logic go = 1'b0;
    logic [47:0] bits = 48'h0;
    logic [5:0] nbits = 6'h0;
    logic hold_sel = 1'b0;
    logic slow = 1'b0;
    logic sel_n, sck, sdi, busy, par, ovr, stable, commit;
    logic [6:0] pm;
    logic [3:0] fm;
    logic [7:0] pm_exp [8] = '{8'h00, 8'h40, 8'h20, 8'h60, 8'h18, 8'h04, 8'h02, 8'h01};
    logic [7:0] sck_exp [4] = '{8'h00, 8'h04, 8'h0C, 8'h08};
    logic [7:0] sel_exp [4] = '{8'h00, 8'h01, 8'h03, 8'h02};
    int error_cnt = 0;
    int total_checks = 0;
    int commits = 0;
    int c0 = 0;
    int cyc = 0;
    always #20 sys_clk = ~sys_clk;
    acp_host_model host (.sys_clk(sys_clk), .go(go), .bits(bits), .nbits(nbits),
        .hold_sel(hold_sel), .slow(slow), .serial_select_low(sel_n), .serial_clk(sck),
        .serial_data_in(sdi), .busy(busy));
    acp_config_top #(.PWRUP_CYC(20)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .reset_pin(reset_pin), .serial_select_low(sel_n), .serial_clk(sck),
        .serial_data_in(sdi), .mode_pin_one(mode[2]), .mode_pin_two(mode[1]),
        .mode_pin_three(mode[0]), .sclk_level(sclk_level), .sel_level(sel_level),
        .cha_out_dis(pm[6]), .chb_out_dis(pm[5]), .cha_power_down(pm[4]),
        .chb_power_down(pm[3]), .cha_standby(pm[2]), .chb_standby(pm[1]),
        .channel_interleave_mode(pm[0]), .gain_3p5db(fm[3]), .ext_ref(fm[2]),
        .cmos_iface(fm[1]), .straight_binary(fm[0]), .parallel_only(par),
        .pin_override(ovr), .outputs_stable(stable), .word_commit(commit));
    task automatic conclude;
        $display("Checks %0d, errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic send(input logic [47:0] b, input logic [5:0] n, input logic hs,
        input logic sl);
        int w;
        w = 0;
        @(negedge sys_clk);
        bits = b;
        nbits = n;
        hold_sel = hs;
        slow = sl;
        go = 1'b1;
        @(negedge sys_clk);
        go = 1'b0;
        @(negedge sys_clk);
        while (busy === 1'b1 && w < 2000) begin
            @(negedge sys_clk);
            w++;
        end
        if (w >= 2000) begin
            error_cnt++;
            $display("Error at %0t: busy %h expected %h", $time, busy, 1'b0);
        end
        // Commit, register and decoded outputs take three cycles
        repeat (4) @(negedge sys_clk);
    endtask
    always @(negedge sys_clk) begin
        if (commit === 1'b1) commits++;
        cyc++;
        if (cyc > 6000) begin
            error_cnt++;
            $display("Error at %0t: cycles %h limit %h", $time, cyc, 6000);
            conclude();
        end
    end
    initial begin
        repeat (3) @(negedge sys_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge sys_clk);
        chk({7'h0, stable}, 8'h00);
        repeat (22) @(negedge sys_clk);
        chk({7'h0, stable}, 8'h01);
        c0 = commits;
        send({32'h0, 8'h14, 8'h38}, 6'd16, 1'b0, 1'b0);
        chk({4'h0, fm}, 8'h0E);
        chk(8'(commits - c0), 8'h01);
        // Two words and five stray bits in one select period, slow clock
        c0 = commits;
        send({11'h0, 8'h14, 8'h20, 8'h16, 8'h10, 5'h15}, 6'd37, 1'b0, 1'b1);
        chk({4'h0, fm}, 8'h03);
        chk(8'(commits - c0), 8'h02);
        send({32'h0, 8'h16, 8'h00}, 6'd16, 1'b1, 1'b0);
        chk({4'h0, fm}, 8'h03);
        chk(8'(commits - c0), 8'h02);
        send({32'h0, 8'h14, 8'hA4}, 6'd16, 1'b0, 1'b0);
        mode = 3'h1;
        repeat (3) @(negedge sys_clk);
        chk({1'b0, pm}, 8'h18);
        chk({7'h0, ovr}, 8'h01);
        // Reset pin stays low across the software reset
        send({32'h0, 8'h00, 8'h02}, 6'd16, 1'b0, 1'b0);
        chk({4'h0, fm}, 8'h00);
        chk({1'b0, pm}, 8'h40);
        send({32'h0, 8'h16, 8'h10}, 6'd16, 1'b0, 1'b0);
        chk({4'h0, fm}, 8'h01);
        // Scaled power-on delay has passed; one cycle is well over the minimum width
        reset_pin = 1'b1;
        @(negedge sys_clk);
        reset_pin = 1'b0;
        repeat (3) @(negedge sys_clk);
        chk({4'h0, fm}, 8'h00);
        chk({7'h0, par}, 8'h00);
        reset_pin = 1'b1;
        mode = 3'h0;
        repeat (30) @(negedge sys_clk);
        chk({7'h0, par}, 8'h01);
        for (int i = 0; i < 4; i++) begin
            sclk_level = 2'(i);
            repeat (3) @(negedge sys_clk);
            chk({4'h0, fm}, sck_exp[i]);
        end
        sclk_level = 2'h0;
        for (int i = 0; i < 4; i++) begin
            sel_level = 2'(i);
            repeat (3) @(negedge sys_clk);
            chk({4'h0, fm}, sel_exp[i]);
        end
        sel_level = ACP_LVL_5_8;
        for (int i = 0; i < 8; i++) begin
            mode = 3'(i);
            repeat (3) @(negedge sys_clk);
            chk({1'b0, pm}, pm_exp[i]);
        end
        // Interleave code with LVDS selected leaves every mode output low
        sel_level = ACP_LVL_GND;
        repeat (3) @(negedge sys_clk);
        chk({1'b0, pm}, 8'h00);
        conclude();
    end
endmodule
